// [rtl/dtf_bus_if.sv]
// Purpose: local register bus between microcontroller end and task file
// Assumes: single clock, strobes one cycle wide, read data one cycle after strobe
// Notes:   no clocking block, testbench joins the two ends here
`timescale 1ns/1ps
interface dtf_bus_if;
  logic [7:0] addr;      // register address
  logic [7:0] wdata;     // write data
  logic       wr;        // write strobe
  logic       rd;        // read strobe
  logic [7:0] rdata;     // read data, valid the cycle after rd
  logic       disk_controller_interrupt_flag;       // disk controller interrupt flag
  modport ctrl (output addr, output wdata, output wr, output rd, input rdata, input disk_controller_interrupt_flag);
  modport dev  (input addr, input wdata, input wr, input rd, output rdata, output disk_controller_interrupt_flag);
endinterface

// [rtl/dtf_ctrl_end.sv]
// Purpose: microcontroller end of the task file bus, with drive select outputs
// Assumes: one request at a time, user waits for ack
// Notes:   drive and head outputs follow writes to the drive/head/size register
`timescale 1ns/1ps
module dtf_ctrl_end
  import dtf_pkg::*;
(
  input  wire logic        clk,           // 125 MHz clock
  input  wire logic        rstn,          // async reset, active low
  dtf_bus_if.ctrl          bus,           // register bus
  input  wire logic        req,           // access request
  input  wire logic        we,            // 1 write, 0 read
  input  wire logic [7:0]  addr,          // register address
  input  wire logic [7:0]  wdata,         // write data
  input  wire logic        head4_mode,    // four-bit head layout in use
  output logic             ack,           // one-cycle completion pulse
  output logic [7:0]       rdata,         // read data, valid with ack
  output logic             irq,           // interrupt flag from device
  output logic             drive_select_pin_high, // drive select bit 1
  output logic             drive_select_pin_low,  // drive select bit 0
  output logic [3:0]       head_select    // head number to drive
);
  typedef enum logic [1:0] {C_IDLE, C_STROBE, C_LATCH, C_ACK} dtf_cstate_type;
  dtf_cstate_type state_q;
  logic [7:0] addr_q, wdata_q, rdata_q, dhs_q;
  logic       wr_q, rd_q;

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= C_IDLE;
      addr_q  <= BYTE_ZERO;
      wdata_q <= BYTE_ZERO;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      rdata_q <= BYTE_ZERO;
    end else begin
      unique case (state_q)
        C_IDLE: if (req) begin
          state_q <= C_STROBE;
          addr_q  <= addr;
          wdata_q <= (we && addr == ADDR_CYL_HI) ?
                     {5'b00000, wdata[CYL_HI_WIDTH-1:0]} : wdata;
          wr_q    <= we;
          rd_q    <= !we;
        end
        C_STROBE: begin
          state_q <= C_LATCH;
          wr_q    <= 1'b0;
          rd_q    <= 1'b0;
        end
        C_LATCH: begin
          state_q <= C_ACK;
          rdata_q <= bus.rdata;
        end
        C_ACK: state_q <= C_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // drive and head outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dhs_q <= BYTE_ZERO;
    end else if (wr_q && addr_q == ADDR_DHS) begin
      dhs_q <= wdata_q;
    end
  end

  assign drive_select_pin_high = head4_mode ? 1'b0 : dhs_q[DHS_DRIVE_HI];
  assign drive_select_pin_low  = head4_mode ? dhs_q[DHS_DRIVE_HI]
                                            : dhs_q[DHS_DRIVE_LO];
  assign head_select           = head4_mode ? dhs_q[3:0] : {1'b0, dhs_q[2:0]};
  assign bus.addr  = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr    = wr_q;
  assign bus.rd    = rd_q;
  assign ack       = (state_q == C_ACK);
  assign rdata     = rdata_q;
  assign irq       = bus.disk_controller_interrupt_flag;
endmodule

// [rtl/dtf_pkg.sv]
// Purpose: shared constants for the disk task file register bank and its controller end
// Assumes: 8-bit register bus, byte addresses on the low address byte
// Notes:   command opcode values and option bit positions are local choices
package dtf_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ERROR   = 8'h21;
  localparam logic [7:0] ADDR_SECTOR  = 8'h23;
  localparam logic [7:0] ADDR_CYL_LO  = 8'h24;
  localparam logic [7:0] ADDR_CYL_HI  = 8'h25;
  localparam logic [7:0] ADDR_DHS     = 8'h26;
  localparam logic [7:0] ADDR_STATUS  = 8'h27;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DHS_ECC_BIT   = 7;
  localparam int DHS_SIZE_HI   = 6;
  localparam int DHS_SIZE_LO   = 5;
  localparam int DHS_DRIVE_HI  = 4;
  localparam int DHS_DRIVE_LO  = 3;
  localparam int CYL_HI_WIDTH  = 3;
  localparam int CYL_WIDTH     = 11;
  localparam int ST_RDY_BIT    = 6;
  localparam int ST_WF_BIT     = 5;
  localparam int ST_SC_BIT     = 4;
  localparam int ST_CIP_BIT    = 1;
  localparam int ST_BUSY_BIT   = 7;
  localparam int ST_ERR_BIT    = 0;
  localparam int ERR_AC_BIT    = 2;
  localparam int CMD_OPT_BIT   = 0;
  // ----------------------------------------------------------------
  // commands: opcode in bits 7:4, option in bit 0
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_SET_PARAM = 4'h0;
  localparam logic [3:0] OP_LOAD_PB   = 4'h1;
  localparam logic [3:0] OP_READ      = 4'h2;
  localparam logic [3:0] OP_WRITE     = 4'h3;
  localparam logic [3:0] OP_FORMAT    = 4'h5;
  // ----------------------------------------------------------------
  // coding modes and lengths
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CODE_MFM, CODE_RLL, CODE_NRZ} dtf_coding_type;
  localparam logic [11:0] LEN_SS00    = 12'h100;
  localparam logic [11:0] LEN_SS01    = 12'h200;
  localparam logic [11:0] LEN_SS10    = 12'h400;
  localparam logic [11:0] LEN_SS11    = 12'h080;
  localparam logic [8:0]  GAP_ADD_STD = 9'h003;
  localparam logic [8:0]  GAP_ADD_NRZ = 9'h006;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
endpackage

// [rtl/dtf_task_file.sv]
// Purpose: task file register bank and command sequencing of the disk formatter
// Assumes: drive pins asynchronous, engine signals on clk
// Notes:   read/write/format run until exec_done from the engine, or until not ready or write fault aborts them
// Summary of operation
// - read/write take 8-bit sector number
// - format uses sector register as gap length
// - load parameter block copies sector to pad
// - eleven-bit cylinder for read, write, format
// - load parameter block loads length/offset, U enables
// - cylinder low 8 bits, high bits 2:0
// - three-bit heads after reset, option selects four
// - bit 7 ECC select, RLL forces ECC
// - size code selects 256/512/1024/128 bytes
// - programmable length 100 to 2048 bytes; code holds an 11-bit length, so at most 2047
// - software keeps size code zero when programmable
// - software validates ECC above 1056 bytes
// - drive bits 4:3 or bit 4
// - head bits 2:0 or 3:0
// - controller drives drive select and head
// - format header byte: bad block, size, head
// - busy reads return status, writes ignored
// - status fixed bits and ready/fault levels
// - abort on not ready or write fault
// - status bit 0 flags non-recoverable error
// - freeze ready/fault at end, read unfreezes
// - command write starts, sets busy, clears interrupt
// - abort sets error register bit 2
`timescale 1ns/1ps
module dtf_task_file
  import dtf_pkg::*;
(
  input  wire logic        clk,             // 125 MHz clock
  input  wire logic        rstn,            // async reset, active low
  dtf_bus_if.dev           bus,             // register bus
  input  wire logic        drive_ready_in,  // drive ready pin
  input  wire logic        write_fault_in,  // write fault pin
  input  wire logic [1:0]  coding_mode,     // dtf_coding_type
  input  wire logic        bad_block,       // bad block flag for format header
  input  wire logic        exec_done,       // engine finished command
  input  wire logic        exec_error,      // engine error with exec_done
  input  wire logic [7:0]  exec_err_code,   // engine error cause bits
  output logic             cmd_start,       // one-cycle start pulse to engine
  output logic [3:0]       cmd_op,          // running opcode
  output logic [7:0]       sector_num,      // target sector
  output logic [10:0]      cylinder_num,    // target cylinder
  output logic [3:0]       head_num,        // head number
  output logic [1:0]       drive_num,       // drive number
  output logic             ecc_enable,      // data field ECC
  output logic [11:0]      data_len,        // data field length in bytes
  output logic [8:0]       gap_len,         // gap 1 and 3 byte count
  output logic [7:0]       pad_byte,        // pad fill value
  output logic [10:0]      wid_offset,      // write id offset
  output logic             prog_en,         // programmable size enabled
  output logic [7:0]       id_header,       // format id header byte
  output logic             abort_pulse      // command aborted
);
  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_RUN} dtf_state_type;
  dtf_state_type state_q;
  logic [7:0]  sector_q, cyl_lo_q, cyl_hi_q, dhs_q, err_q, cmd_q, pad_q, rdata_q;
  logic [10:0] plen_q;
  logic        head4_q, prog_q, err_flag_q, dci_q, frz_q, frz_rdy_q, frz_wf_q;
  logic [2:0]  rdy_sync_q, wf_sync_q;
  logic        rdy_q, wf_q, start_q, abort_q;
  logic        command_in_progress, legal, fault, st_rd, cmd_wr, reg_wr, finish;
  logic [7:0]  status;

  // ----------------------------------------------------------------
  // pin synchronisers, change taken once stages 2 and 3 agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdy_sync_q <= 3'b000;
      wf_sync_q  <= 3'b000;
      rdy_q      <= 1'b0;
      wf_q       <= 1'b0;
    end else begin
      rdy_sync_q <= {rdy_sync_q[1:0], drive_ready_in};
      wf_sync_q  <= {wf_sync_q[1:0], write_fault_in};
      if (rdy_sync_q[1] == rdy_sync_q[2]) rdy_q <= rdy_sync_q[2];
      if (wf_sync_q[1] == wf_sync_q[2]) wf_q <= wf_sync_q[2];
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign command_in_progress    = (state_q != S_IDLE);
  assign st_rd  = bus.rd && (command_in_progress || bus.addr == ADDR_STATUS);
  assign reg_wr = bus.wr && !command_in_progress;
  assign cmd_wr = reg_wr && bus.addr == ADDR_STATUS;
  assign fault  = !rdy_q || wf_q;
  assign legal  = cmd_q[7:4] inside {OP_SET_PARAM, OP_LOAD_PB, OP_READ, OP_WRITE, OP_FORMAT};
  assign finish = (state_q == S_CHECK && (fault || !legal || cmd_q[7:4] == OP_SET_PARAM ||
                   cmd_q[7:4] == OP_LOAD_PB)) ||
                  (state_q == S_RUN && (fault || exec_done));

  // ----------------------------------------------------------------
  // task file registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sector_q <= BYTE_ZERO;
      cyl_lo_q <= BYTE_ZERO;
      cyl_hi_q <= BYTE_ZERO;
      dhs_q    <= BYTE_ZERO;
      cmd_q    <= BYTE_ZERO;
    end else if (reg_wr) begin
      unique case (bus.addr)
        ADDR_SECTOR: sector_q <= bus.wdata;
        ADDR_CYL_LO: cyl_lo_q <= bus.wdata;
        ADDR_CYL_HI: cyl_hi_q <= bus.wdata;
        ADDR_DHS:    dhs_q    <= bus.wdata;
        ADDR_STATUS: cmd_q    <= bus.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      start_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      abort_q <= 1'b0;
      unique case (state_q)
        S_IDLE:  if (cmd_wr) state_q <= S_CHECK;
        S_CHECK: begin
          if (fault || !legal) begin
            state_q <= S_IDLE;
            abort_q <= 1'b1;
          end else if (cmd_q[7:4] == OP_SET_PARAM || cmd_q[7:4] == OP_LOAD_PB) begin
            state_q <= S_IDLE;
          end else begin
            state_q <= S_RUN;
            start_q <= 1'b1;
          end
        end
        S_RUN: begin
          if (fault) begin
            state_q <= S_IDLE;
            abort_q <= 1'b1;
          end else if (exec_done) begin
            state_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // internal parameter registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      head4_q <= 1'b0;
      prog_q  <= 1'b0;
      pad_q   <= BYTE_ZERO;
      plen_q  <= '0;
    end else if (state_q == S_CHECK && !fault) begin
      if (cmd_q[7:4] == OP_SET_PARAM) head4_q <= cmd_q[CMD_OPT_BIT];
      if (cmd_q[7:4] == OP_LOAD_PB) begin
        pad_q  <= sector_q;
        plen_q <= {cyl_hi_q[CYL_HI_WIDTH-1:0], cyl_lo_q};
        prog_q <= cmd_q[CMD_OPT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // error, status latch and interrupt flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_q      <= BYTE_ZERO;
      err_flag_q <= 1'b0;
    end else if (cmd_wr) begin
      err_q      <= BYTE_ZERO;
      err_flag_q <= 1'b0;
    end else if (state_q != S_IDLE && finish && (fault || !legal)) begin
      err_q[ERR_AC_BIT] <= 1'b1;
      err_flag_q        <= 1'b1;
    end else if (state_q == S_RUN && exec_done && exec_error) begin
      err_q      <= exec_err_code;
      err_flag_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frz_q     <= 1'b0;
      frz_rdy_q <= 1'b0;
      frz_wf_q  <= 1'b0;
    end else if (finish) begin
      frz_q     <= 1'b1;
      frz_rdy_q <= rdy_q;
      frz_wf_q  <= wf_q;
    end else if (st_rd && !command_in_progress) begin
      frz_q     <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dci_q <= 1'b0;
    end else if (finish) begin
      dci_q <= 1'b1;
    end else if (cmd_wr || (st_rd && !command_in_progress)) begin
      dci_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    status              = BYTE_ZERO;
    status[ST_RDY_BIT]  = frz_q ? frz_rdy_q : rdy_q;
    status[ST_WF_BIT]   = frz_q ? frz_wf_q : wf_q;
    status[ST_SC_BIT]   = 1'b1;
    status[ST_ERR_BIT]  = err_flag_q;
    status[ST_BUSY_BIT] = command_in_progress;
    status[ST_CIP_BIT]  = command_in_progress;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= BYTE_ZERO;
    end else if (bus.rd) begin
      if (st_rd) begin
        rdata_q <= status;
      end else begin
        unique case (bus.addr)
          ADDR_ERROR:  rdata_q <= err_q;
          ADDR_SECTOR: rdata_q <= sector_q;
          ADDR_CYL_LO: rdata_q <= cyl_lo_q;
          ADDR_CYL_HI: rdata_q <= cyl_hi_q;
          ADDR_DHS:    rdata_q <= dhs_q;
          default:     rdata_q <= BYTE_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  always_comb begin
    unique case (dhs_q[DHS_SIZE_HI:DHS_SIZE_LO])
      2'b00: data_len = LEN_SS00;
      2'b01: data_len = LEN_SS01;
      2'b10: data_len = LEN_SS10;
      2'b11: data_len = LEN_SS11;
    endcase
    if (prog_q) data_len = {1'b0, plen_q};
  end

  assign bus.rdata    = rdata_q;
  assign bus.disk_controller_interrupt_flag      = dci_q;
  assign cmd_start    = start_q;
  assign abort_pulse  = abort_q;
  assign cmd_op       = cmd_q[7:4];
  assign sector_num   = sector_q;
  assign cylinder_num = {cyl_hi_q[CYL_HI_WIDTH-1:0], cyl_lo_q};
  assign head_num     = head4_q ? dhs_q[3:0] : {1'b0, dhs_q[2:0]};
  assign drive_num    = head4_q ? {1'b0, dhs_q[DHS_DRIVE_HI]}
                                : dhs_q[DHS_DRIVE_HI:DHS_DRIVE_LO];
  assign ecc_enable   = dhs_q[DHS_ECC_BIT] || coding_mode == CODE_RLL;
  assign gap_len      = {1'b0, sector_q} + ((coding_mode == CODE_NRZ) ? GAP_ADD_NRZ
                                                                      : GAP_ADD_STD);
  assign pad_byte     = pad_q;
  assign wid_offset   = plen_q;
  assign prog_en      = prog_q;
  assign id_header    = {bad_block, dhs_q[DHS_SIZE_HI:DHS_SIZE_LO], 1'b0,
                         head4_q ? dhs_q[3:0] : {1'b0, dhs_q[2:0]}};
endmodule

// [tb/dtf_bus_monitor.sv]
// Purpose: protocol checks on the task file register bus
// Assumes: one clock, active-low async reset
// Notes:   sees only the interface signals
`timescale 1ns/1ps
module dtf_bus_monitor
  import dtf_pkg::*;
(
  input wire logic       clk,   // clock
  input wire logic       rstn,  // async reset, active low
  input wire logic [7:0] addr,  // register address
  input wire logic [7:0] wdata, // write data
  input wire logic       wr,    // write strobe
  input wire logic       rd,    // read strobe
  input wire logic [7:0] rdata, // read data
  input wire logic       disk_controller_interrupt_flag    // interrupt flag
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rstn);
  status_fixed_a: assert property (
    rd && addr == ADDR_STATUS |=> rdata[4] && rdata[3:2] == 2'b00 && rdata[7] == rdata[1])
    else $error("status fixed bits wrong");
  stat_read_irq_a: assert property (rd && addr == ADDR_STATUS && disk_controller_interrupt_flag |=> !disk_controller_interrupt_flag)
    else $error("status read left interrupt set");
  cmd_write_irq_a: assert property (wr && addr == ADDR_STATUS && disk_controller_interrupt_flag |=> !disk_controller_interrupt_flag)
    else $error("command write left interrupt set");
  unmapped_zero_a: assert property (
    rd && addr == 8'h20 |=> rdata == BYTE_ZERO || rdata[ST_CIP_BIT])
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd |=> $stable(rdata))
    else $error("read data moved without read");
  strobe_excl_a: assert property (!(wr && rd))
    else $error("read and write together");
  wr_pulse_a: assert property (wr |=> !wr)
    else $error("write strobe longer than one cycle");
  cyl_hi_zero_a: assert property (wr && addr == ADDR_CYL_HI |-> wdata[7:3] == 5'h00)
    else $error("cylinder high unused bits written nonzero");
endmodule

// [tb/tb.sv]
// Purpose: self-checking bench joining controller end and task file
// Assumes: 125 MHz clock, pins held steady around accesses
// Notes:   reset values and register rows first, then decoded outputs, commands, aborts and reset
`timescale 1ns/1ps
module tb;
  import dtf_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } dtf_row_type;
  logic        clk, rstn, req, we, head4_mode, ack, irq, ds_hi, ds_lo;
  logic        drive_ready_in, write_fault_in, bad_block, exec_done, exec_error;
  logic [7:0]  exec_err_code;
  logic        cmd_start, ecc_enable, prog_en, abort_pulse;
  logic [7:0]  addr, wdata, rdata, got, sector_num, pad_byte, id_header;
  logic [3:0]  head_select, cmd_op, head_num;
  logic [1:0]  coding_mode, drive_num;
  logic [10:0] cylinder_num, wid_offset;
  logic [11:0] data_len;
  logic [8:0]  gap_len;
  int          failures, n_tests, n_start, n_abort, s0;
  dtf_row_type rows [5];
  logic [11:0] lens [4];
  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  dtf_bus_if u_dtf_bus_if ();
  dtf_ctrl_end u_dtf_ctrl_end (.clk, .rstn, .bus(u_dtf_bus_if), .req, .we, .addr, .wdata,
    .head4_mode, .ack, .rdata, .irq, .drive_select_pin_high(ds_hi),
    .drive_select_pin_low(ds_lo), .head_select);
  dtf_task_file u_dtf_task_file (.clk, .rstn, .bus(u_dtf_bus_if), .drive_ready_in,
    .write_fault_in, .coding_mode, .bad_block, .exec_done, .exec_error,
    .exec_err_code, .cmd_start, .cmd_op, .sector_num, .cylinder_num, .head_num,
    .drive_num, .ecc_enable, .data_len, .gap_len, .pad_byte, .wid_offset, .prog_en,
    .id_header, .abort_pulse);
  dtf_bus_monitor u_dtf_bus_monitor (.clk, .rstn, .addr(u_dtf_bus_if.addr),
    .wdata(u_dtf_bus_if.wdata), .wr(u_dtf_bus_if.wr), .rd(u_dtf_bus_if.rd),
    .rdata(u_dtf_bus_if.rdata), .disk_controller_interrupt_flag(u_dtf_bus_if.disk_controller_interrupt_flag));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    n_start <= n_start + int'(cmd_start);
    n_abort <= n_abort + int'(abort_pulse);
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] exp, input logic [15:0] act);
    n_tests++;
    if (act !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      failures++;
      conclude();
    end
    got = rdata;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0; rstn = 0; req = 0; we = 0; addr = 0; wdata = 0; head4_mode = 0;
    drive_ready_in = 1; write_fault_in = 0; bad_block = 1; exec_done = 0;
    exec_error = 0; exec_err_code = 8'h00;
    coding_mode = 2'd0; n_start = 0; n_abort = 0; failures = 0; n_tests = 0;
    lens = '{12'h100, 12'h200, 12'h400, 12'h080};
    rows = '{'{ADDR_SECTOR, 8'hff, 8'hff}, '{ADDR_CYL_LO, 8'ha5, 8'ha5},
      '{ADDR_CYL_HI, 8'hff, 8'h07}, '{ADDR_DHS, 8'h6d, 8'h6d}, '{8'h20, 8'h55, 8'h00}};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(negedge clk);
    chk(16'h100, 16'(data_len));
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(16'h50, 16'(got));
    foreach (rows[k]) begin
      acc(1'b1, rows[k].a, rows[k].d);
      acc(1'b0, rows[k].a, 8'h00);
      chk(16'(rows[k].e), 16'(got));
    end
    chk(16'hff, 16'(sector_num));
    chk(16'h7a5, 16'(cylinder_num));
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, ADDR_DHS, {s[0], s[1:0], 5'b01101});
      chk(16'(lens[s]), 16'(data_len));
      chk(16'(s[0]), 16'(ecc_enable));
      chk(16'({1'b1, s[1:0], 5'b00101}), 16'(id_header));
      chk(16'h15, 16'({drive_num, head_num}));
      chk(16'h15, 16'({ds_hi, ds_lo, head_select}));
    end
    acc(1'b1, ADDR_DHS, 8'h2d);
    @(posedge clk) coding_mode <= 2'd1;
    acc(1'b1, ADDR_SECTOR, 8'h10);
    chk(16'h1, 16'(ecc_enable));
    @(posedge clk) coding_mode <= 2'd0;
    repeat (2) @(negedge clk);
    chk(16'h13, 16'(gap_len));
    @(posedge clk) coding_mode <= 2'd2;
    repeat (2) @(negedge clk);
    chk(16'h16, 16'(gap_len));
    @(posedge clk) coding_mode <= 2'd0;
    acc(1'b1, ADDR_CYL_LO, 8'h00);
    acc(1'b1, ADDR_CYL_HI, 8'h02);
    acc(1'b1, ADDR_SECTOR, 8'h3c);
    acc(1'b1, ADDR_STATUS, 8'h11);
    repeat (4) @(negedge clk);
    chk(16'h3c, 16'(pad_byte));
    chk(16'h1, 16'(prog_en));
    chk(16'h200, 16'(wid_offset));
    chk(16'h200, 16'(data_len));
    acc(1'b1, ADDR_STATUS, 8'h01);
    @(posedge clk) head4_mode <= 1'b1;
    acc(1'b1, ADDR_DHS, 8'h1b);
    chk(16'hbb, 16'({head_num, head_select}));
    chk(16'h5, 16'({ds_hi, ds_lo, drive_num}));
    chk(16'h8b, 16'(id_header));
    s0 = n_start;
    acc(1'b1, ADDR_STATUS, 8'h20);
    repeat (2) @(negedge clk);
    chk(16'h12, 16'({n_start - s0, cmd_op}));
    acc(1'b0, ADDR_SECTOR, 8'h00);
    chk(16'hd2, 16'(got));
    acc(1'b1, ADDR_SECTOR, 8'h77);
    @(posedge clk) exec_done <= 1'b1;
    @(posedge clk) exec_done <= 1'b0;
    repeat (3) @(negedge clk);
    chk(16'h1, 16'(irq));
    @(posedge clk) drive_ready_in <= 1'b0;
    repeat (10) @(posedge clk);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(16'h50, 16'(got));
    chk(16'h0, 16'(irq));
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(16'h10, 16'(got));
    @(posedge clk) drive_ready_in <= 1'b1;
    repeat (10) @(posedge clk);
    acc(1'b0, ADDR_SECTOR, 8'h00);
    chk(16'h3c, 16'(got));
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) write_fault_in <= i[0];
      repeat (10) @(posedge clk);
      acc(1'b1, ADDR_STATUS, i[0] ? 8'h30 : 8'hf0);
      repeat (4) @(negedge clk);
      chk(16'(i + 1), 16'(n_abort));
      chk(16'h1, 16'(irq));
      acc(1'b0, ADDR_STATUS, 8'h00);
      chk(16'({2'b01, i[0], 5'h11}), 16'(got));
      acc(1'b0, ADDR_ERROR, 8'h00);
      chk(16'h04, 16'(got));
    end
    @(posedge clk) write_fault_in <= 1'b0;
    repeat (10) @(posedge clk);
    acc(1'b1, ADDR_STATUS, 8'h20);
    @(posedge clk) begin
      exec_done     <= 1'b1;
      exec_error    <= 1'b1;
      exec_err_code <= 8'h10;
    end
    @(posedge clk) begin
      exec_done     <= 1'b0;
      exec_error    <= 1'b0;
    end
    repeat (3) @(negedge clk);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk(16'h51, 16'(got));
    acc(1'b0, ADDR_ERROR, 8'h00);
    chk(16'h10, 16'(got));
    @(posedge clk) rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    acc(1'b0, ADDR_SECTOR, 8'h00);
    chk(16'h0010, 16'({got, data_len[11:4]}));
    conclude();
  end
endmodule
